// file: gpb_defines.vh
// Constants for the general purpose I/O pin mux bank.
`ifndef GPB_DEFINES_VH
`define GPB_DEFINES_VH
`define GPB_NUM_PINS 56
`define GPB_NUM_INT_PINS 16
`define GPB_PIN_FAN_SPEED_0 17
`define GPB_PIN_FAN_SPEED_1 1
`define GPB_PIN_FAN_SPEED_2 6
`define GPB_PIN_FAN_SPEED_3 7
`define GPB_PIN_PCI_STOP 15
`define GPB_PIN_LED 24
`define GPB_PIN_CPU_STOP 25
`define GPB_PIN_PWR_GOOD 49
// Reset value of the native select: one means native function after reset.
`define GPB_NATIVE_RST 56'h00FE_0F00_E608_8800
// Reset value of the direction: one means output; plain outputs default as outputs.
`define GPB_DIR_RST 56'h0000_181D_0015_0000
`define GPB_LEVEL_RST 56'h0000_0000_0000_0000
`define GPB_ROUTE_NONE 2'h0
`define GPB_ROUTE_SMI 2'h1
`define GPB_ROUTE_SCI 2'h2
`endif

// file: gpb_pin_cell.v
// One shared pin: mux between native function and GPIO use, with open-drain option.
`timescale 1ns/100ps
`default_nettype none
module gpb_pin_cell #(
    parameter OPEN_DRAIN = 0
) (
    input wire native_sel,
    input wire gpio_dir_out,
    input wire gpio_level,
    input wire native_out,
    input wire native_oe_n,
    output wire pin_out,
    output wire pin_oe_n
);
    wire want_out;
    wire want_oe_n;
    assign want_out = native_sel ? native_out : gpio_level;
    assign want_oe_n = native_sel ? native_oe_n : ~gpio_dir_out;
    // An open-drain pin only ever drives low; a one releases it to the pull-up.
    assign pin_out = (OPEN_DRAIN != 0) ? 1'b0 : want_out;
    assign pin_oe_n = (OPEN_DRAIN != 0) ? (want_oe_n | want_out) : want_oe_n;
endmodule // gpb_pin_cell
`default_nettype wire

// file: gpb_pin_mux_bank.v
// General purpose I/O bank with native sharing and input interrupt routing.
`timescale 1ns/100ps
`default_nettype none
`include "gpb_defines.vh"
// What this block does
// - Each general input 0 to 15 can raise a management or ACPI interrupt.
// - One input routes to at most one interrupt destination, never both.
// - The LED pin 24 keeps its state across a reset-port reset.
// - The power-good pin 49 is never actively driven high.
// - Pin 49 as output releases for one and drives low for zero.
// - Pin 25 comes out of reset as processor stop-clock request.
// - Pin 15 comes out of reset as PCI clock stop request.
// - Each of the four fan speed inputs may serve as plain GPIO.
module gpb_pin_mux_bank #(
    parameter NPINS = `GPB_NUM_PINS,
    parameter NINT = `GPB_NUM_INT_PINS
) (
    input wire CLK,
    input wire RSTN,
    input wire PORT_RESET,
    input wire [NPINS-1:0] NATIVE_SEL_WR,
    input wire [NPINS-1:0] NATIVE_SEL_IN,
    input wire [NPINS-1:0] DIR_WR,
    input wire [NPINS-1:0] DIR_IN,
    input wire [NPINS-1:0] LEVEL_WR,
    input wire [NPINS-1:0] LEVEL_IN,
    input wire ROUTE_WR,
    input wire [3:0] ROUTE_IDX,
    input wire [1:0] ROUTE_IN,
    input wire [NINT-1:0] INT_CLEAR,
    input wire [NPINS-1:0] NATIVE_OUT,
    input wire [NPINS-1:0] NATIVE_OE_N,
    input wire [NPINS-1:0] PIN_IN,
    output wire [NPINS-1:0] PIN_OUT,
    output wire [NPINS-1:0] PIN_OE_N,
    output reg [NPINS-1:0] GENERAL_INPUT,
    output wire [3:0] FAN_SPEED_INPUT,
    output reg [NINT-1:0] INT_STATUS,
    output reg SYSTEM_MGMT_INTERRUPT,
    output reg ACPI_CONTROL_INTERRUPT
);
    reg [NPINS-1:0] native_q;
    reg [NPINS-1:0] dir_q;
    reg [NPINS-1:0] level_q;
    reg [NPINS-1:0] in_prev_q;
    reg [2*NINT-1:0] route_q;
    reg [NINT-1:0] smi_mask;
    reg [NINT-1:0] sci_mask;
    wire [NPINS-1:0] keep;
    wire [NINT-1:0] rise;
    integer k;

    // The LED pin lives in a domain that the reset port must not disturb.
    assign keep = {{(NPINS-`GPB_PIN_LED-1){1'b0}}, 1'b1, {`GPB_PIN_LED{1'b0}}};

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            native_q <= `GPB_NATIVE_RST;
            dir_q <= `GPB_DIR_RST;
            level_q <= `GPB_LEVEL_RST;
        end else if (PORT_RESET) begin
            native_q <= (native_q & keep) | (`GPB_NATIVE_RST & ~keep);
            dir_q <= (dir_q & keep) | (`GPB_DIR_RST & ~keep);
            level_q <= (level_q & keep) | (`GPB_LEVEL_RST & ~keep);
        end else begin
            native_q <= (native_q & ~NATIVE_SEL_WR) | (NATIVE_SEL_IN & NATIVE_SEL_WR);
            dir_q <= (dir_q & ~DIR_WR) | (DIR_IN & DIR_WR);
            level_q <= (level_q & ~LEVEL_WR) | (LEVEL_IN & LEVEL_WR);
        end
    end

    // Route field per input: a single two-bit code, so both destinations cannot be chosen.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            route_q <= {(2*NINT){1'b0}};
        end else if (ROUTE_WR) begin
            if (ROUTE_IN == `GPB_ROUTE_SMI || ROUTE_IN == `GPB_ROUTE_SCI) begin
                route_q[ROUTE_IDX*2 +: 2] <= ROUTE_IN;
            end else begin
                route_q[ROUTE_IDX*2 +: 2] <= `GPB_ROUTE_NONE;
            end
        end
    end

    always @* begin
        smi_mask = {NINT{1'b0}};
        sci_mask = {NINT{1'b0}};
        for (k = 0; k < NINT; k = k + 1) begin
            smi_mask[k] = (route_q[k*2 +: 2] == `GPB_ROUTE_SMI);
            sci_mask[k] = (route_q[k*2 +: 2] == `GPB_ROUTE_SCI);
        end
    end

    // Inputs are read only while in GPIO use; native pins show zero.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            GENERAL_INPUT <= {NPINS{1'b0}};
            in_prev_q <= {NPINS{1'b0}};
        end else begin
            GENERAL_INPUT <= PIN_IN & ~native_q;
            in_prev_q <= PIN_IN & ~native_q & ~dir_q;
        end
    end

    assign rise = PIN_IN[NINT-1:0] & ~native_q[NINT-1:0] & ~dir_q[NINT-1:0]
        & ~in_prev_q[NINT-1:0];

    // A new event in the clearing cycle wins, so no edge is lost.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            INT_STATUS <= {NINT{1'b0}};
            SYSTEM_MGMT_INTERRUPT <= 1'b0;
            ACPI_CONTROL_INTERRUPT <= 1'b0;
        end else begin
            INT_STATUS <= (INT_STATUS & ~INT_CLEAR) | (rise & (smi_mask | sci_mask));
            SYSTEM_MGMT_INTERRUPT <= |(INT_STATUS & smi_mask);
            ACPI_CONTROL_INTERRUPT <= |(INT_STATUS & sci_mask);
        end
    end

    // Speed inputs reach the measurement logic only in native use.
    assign FAN_SPEED_INPUT = {
        PIN_IN[`GPB_PIN_FAN_SPEED_3] & native_q[`GPB_PIN_FAN_SPEED_3],
        PIN_IN[`GPB_PIN_FAN_SPEED_2] & native_q[`GPB_PIN_FAN_SPEED_2],
        PIN_IN[`GPB_PIN_FAN_SPEED_1] & native_q[`GPB_PIN_FAN_SPEED_1],
        PIN_IN[`GPB_PIN_FAN_SPEED_0] & native_q[`GPB_PIN_FAN_SPEED_0]};

    genvar g;
    generate
        for (g = 0; g < NPINS; g = g + 1) begin : g_pin
            gpb_pin_cell #(
                .OPEN_DRAIN(g == `GPB_PIN_PWR_GOOD)
            ) u_cell (
                .native_sel(native_q[g]),
                .gpio_dir_out(dir_q[g]),
                .gpio_level(level_q[g]),
                .native_out(NATIVE_OUT[g]),
                .native_oe_n(NATIVE_OE_N[g]),
                .pin_out(PIN_OUT[g]),
                .pin_oe_n(PIN_OE_N[g])
            );
        end
    endgenerate
endmodule // gpb_pin_mux_bank
`default_nettype wire

// file: gpb_mux_sva.sv
// Checker for the GPIO pin mux bank.
`timescale 1ns/100ps
`default_nettype none
module gpb_mux_sva #(parameter NPINS = 56, parameter NINT = 16) (
    input wire CLK,
    input wire RSTN,
    input wire PORT_RESET,
    input wire [NPINS-1:0] NATIVE_OUT,
    input wire [NPINS-1:0] NATIVE_OE_N,
    input wire [NPINS-1:0] PIN_IN,
    input wire [NPINS-1:0] PIN_OUT,
    input wire [NPINS-1:0] PIN_OE_N,
    input wire [3:0] FAN_SPEED_INPUT,
    input wire [NINT-1:0] INT_STATUS,
    input wire SYSTEM_MGMT_INTERRUPT,
    input wire ACPI_CONTROL_INTERRUPT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    a_pwr_never_high: assert property (PIN_OUT[49] == 1'b0) else $error("pin 49 high");
    a_cpu_stop_rst: assert property ($rose(RSTN) |-> PIN_OE_N[25] == NATIVE_OE_N[25]) else $error("pin 25");
    a_pci_stop_rst: assert property ($rose(RSTN) |-> PIN_OE_N[15] == NATIVE_OE_N[15]) else $error("pin 15");
    a_led_kept: assert property (PORT_RESET ##1 $stable(NATIVE_OUT[24]) && $stable(NATIVE_OE_N[24])
        |-> $stable(PIN_OUT[24]) && $stable(PIN_OE_N[24])) else $error("pin 24 lost");
    a_fan_native: assert property (FAN_SPEED_INPUT[0] |-> PIN_IN[17]) else $error("fan input");
    a_int_cause: assert property (|(INT_STATUS & ~$past(INT_STATUS)) |->
        |($past(PIN_IN[NINT-1:0]) & ~$past(PIN_IN[NINT-1:0], 2))) else $error("stray status");
    a_irq_quiet: assert property (INT_STATUS == '0 |=> !SYSTEM_MGMT_INTERRUPT && !ACPI_CONTROL_INTERRUPT)
        else $error("stray interrupt");
    a_route_excl: assert property ($onehot(INT_STATUS) |=> !(SYSTEM_MGMT_INTERRUPT && ACPI_CONTROL_INTERRUPT))
        else $error("both interrupts");
    c_mgmt: cover property (SYSTEM_MGMT_INTERRUPT);
    c_acpi: cover property (ACPI_CONTROL_INTERRUPT);
    c_port_reset: cover property (PORT_RESET);
endmodule // gpb_mux_sva
bind gpb_pin_mux_bank gpb_mux_sva #(.NPINS(NPINS), .NINT(NINT)) chk (.*);
`default_nettype wire

// file: gpb_tb.sv
// Self-checking bench for the GPIO pin mux bank.
`timescale 1ns/100ps
`default_nettype none
`include "gpb_defines.vh"
module tb_top;
    logic CLK, RSTN, PORT_RESET, ROUTE_WR, SYSTEM_MGMT_INTERRUPT, ACPI_CONTROL_INTERRUPT;
    logic [55:0] NATIVE_SEL_WR, NATIVE_SEL_IN, DIR_WR, DIR_IN, LEVEL_WR, LEVEL_IN;
    logic [55:0] NATIVE_OUT, NATIVE_OE_N, PIN_IN, PIN_OUT, PIN_OE_N, GENERAL_INPUT;
    logic [55:0] nat, dir, lvl, ee, eo;
    logic [15:0] INT_CLEAR, INT_STATUS;
    logic [3:0] ROUTE_IDX, FAN_SPEED_INPUT;
    logic [1:0] ROUTE_IN;
    integer bad_count = 0, checked = 0, seed = 32'h16AD, i, k;
    gpb_pin_mux_bank dut (.*);
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task cmp(input string n, input logic [55:0] e, input logic [55:0] g);
        checked = checked + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task finish_test;
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Pin 49 can only pull low, so a native one must release it as well.
    task chk;
        for (k = 0; k < 56; k = k + 1) begin
            ee[k] = nat[k] ? NATIVE_OE_N[k] || (k == 49 && NATIVE_OUT[k]) : !dir[k] || (k == 49 && lvl[k]);
            eo[k] = (nat[k] ? NATIVE_OUT[k] : lvl[k]) && k != 49;
        end
        cmp("oe_n", ee, PIN_OE_N);
        cmp("fan", {PIN_IN[7] & nat[7], PIN_IN[6] & nat[6], PIN_IN[1] & nat[1], PIN_IN[17] & nat[17]}, FAN_SPEED_INPUT);
        cmp("out", eo | PIN_OE_N, PIN_OUT | PIN_OE_N);
        cmp("gpio_in", PIN_IN & ~nat, GENERAL_INPUT);
    endtask
    initial begin
        {RSTN, PORT_RESET, ROUTE_WR, ROUTE_IDX, ROUTE_IN, INT_CLEAR} = 0;
        {NATIVE_SEL_WR, DIR_WR, LEVEL_WR, NATIVE_SEL_IN, DIR_IN, LEVEL_IN, PIN_IN} = 0;
        {NATIVE_OUT, NATIVE_OE_N} = 0;
        {nat, dir, lvl} = {`GPB_NATIVE_RST, `GPB_DIR_RST, 56'h0};
        repeat (12) @(negedge CLK);
        RSTN = 1'b1;
        @(negedge CLK);
        chk;
        for (i = 0; i < 40; i = i + 1) begin
            for (k = 0; k < 56; k = k + 1)
                {NATIVE_SEL_WR[k], NATIVE_SEL_IN[k], DIR_WR[k], DIR_IN[k], LEVEL_WR[k],
                    LEVEL_IN[k], PIN_IN[k], NATIVE_OUT[k], NATIVE_OE_N[k]} = $random(seed);
            {NATIVE_SEL_WR[47:44], DIR_WR[47:44], LEVEL_WR[47:44]} = 0;
            PORT_RESET = (i % 8 == 7);
            if (PORT_RESET) begin
                nat = (`GPB_NATIVE_RST & ~56'h100_0000) | (nat & 56'h100_0000);
                dir = (`GPB_DIR_RST & ~56'h100_0000) | (dir & 56'h100_0000);
                lvl = lvl & 56'h100_0000;
            end else begin
                nat = (nat & ~NATIVE_SEL_WR) | (NATIVE_SEL_IN & NATIVE_SEL_WR);
                dir = (dir & ~DIR_WR) | (DIR_IN & DIR_WR);
                lvl = (lvl & ~LEVEL_WR) | (LEVEL_IN & LEVEL_WR);
            end
            @(negedge CLK);
            {PORT_RESET, NATIVE_SEL_WR, DIR_WR, LEVEL_WR} = 0;
            @(negedge CLK);
            chk;
        end
        {NATIVE_SEL_IN, DIR_IN} = 0;
        for (i = 0; i < 4; i = i + 1) begin
            k = {$random(seed)} % 16;
            {NATIVE_SEL_WR[k], DIR_WR[k], ROUTE_WR, ROUTE_IDX, ROUTE_IN} = {3'h7, k[3:0], i[1:0]};
            {PIN_IN[k], nat[k], dir[k]} = 0;
            @(negedge CLK);
            {NATIVE_SEL_WR, DIR_WR, ROUTE_WR} = 0;
            @(negedge CLK);
            PIN_IN[k] = 1'b1;
            repeat (3) @(negedge CLK);
            cmp("irq", {i == 1 || i == 2, i == 1, i == 2}, {INT_STATUS[k], SYSTEM_MGMT_INTERRUPT, ACPI_CONTROL_INTERRUPT});
            INT_CLEAR[k] = 1'b1;
            @(negedge CLK);
            INT_CLEAR = 0;
            repeat (2) @(negedge CLK);
            cmp("irq_clear", 3'h0, {INT_STATUS[k], SYSTEM_MGMT_INTERRUPT, ACPI_CONTROL_INTERRUPT});
        end
        chk;
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
